// *** rtl/frrl_core.sv ***
// fault retry response logic: response register and retry sequencer
// assumes fault, restart_ok and clear inputs are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module frrl_core (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register write port
  input wire frrl_pkg::frrl_wr_t wr_port,
  // fault and power-stage status
  input wire logic fault,
  input wire logic restart_ok,
  input wire logic other_fault,
  // clearing actions
  input wire logic clear_bit,
  input wire logic clear_faults,
  input wire logic cmd_off,
  input wire logic bias_lost,
  // outputs
  output frrl_pkg::frrl_resp_t response_rd,
  output logic [15:0] time_unit_rd,
  output logic output_enable,
  output logic restart_pulse,
  output logic fault_latched,
  output logic [2:0] attempts
);
  import frrl_pkg::*;
  // ****************************************************************
  // helpers
  // ****************************************************************
  // delay in clocks: unit shifted by the delay code
  function automatic logic [FRRL_CNT_W-1:0] delay_clocks(input logic [2:0] code,
                                                          input logic [15:0] unit);
    delay_clocks = FRRL_CNT_W'(unit) << code;
  endfunction
  // ****************************************************************
  // registers
  // ****************************************************************
  frrl_resp_t cfg; // input_overvoltage_warning_response
  logic [15:0] unit; // delay time unit in clocks
  frrl_resp_t next_cfg;
  logic [15:0] next_unit;
  // register writes by command code
  always_comb begin
    next_cfg = cfg;
    next_unit = unit;
    if (wr_port.wr && wr_port.cmd == FRRL_CMD_RESPONSE) begin
      next_cfg = frrl_resp_t'(wr_port.data[7:0]);
    end
    if (wr_port.wr && wr_port.cmd == FRRL_CMD_TIME_UNIT) begin
      next_unit = wr_port.data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= frrl_resp_t'(FRRL_RESPONSE_RESET);
      unit <= FRRL_UNIT_RESET;
    end else begin
      cfg <= next_cfg;
      unit <= next_unit;
    end
  end
  assign response_rd = cfg;
  assign time_unit_rd = unit;
  // ****************************************************************
  // sequencer
  // ****************************************************************
  frrl_state_t state; // sequencer state
  frrl_state_t next_state;
  logic [2:0] tries; // restarts made
  logic [2:0] next_tries;
  logic next_oe;
  logic next_pulse;
  logic tmr_start; // load delay timer
  logic tmr_done; // delay ended
  logic cleared; // any clearing action
  logic limit_hit; // permitted restarts used up
  assign cleared = clear_bit | clear_faults | cmd_off | bias_lost;
  assign limit_hit = (cfg.retries != FRRL_RETRY_FOREVER) && (tries >= cfg.retries);
  // next state of the fault sequencer
  always_comb begin
    next_state = state;
    next_tries = tries;
    next_oe = output_enable;
    next_pulse = 1'b0;
    tmr_start = 1'b0;
    case (state)
      // normal operation
      FRRL_RUN: begin
        next_oe = 1'b1;
        next_tries = '0;
        if (fault) begin
          case (cfg.response)
            FRRL_RESP_IGNORE: next_state = FRRL_RUN;
            FRRL_RESP_CONTINUE: begin
              tmr_start = 1'b1;
              next_state = FRRL_CONT_WAIT;
            end
            FRRL_RESP_DISABLE_RETRY: begin
              next_oe = 1'b0;
              if (cfg.retries == FRRL_RETRY_NONE) begin
                next_state = FRRL_LATCHED;
              end else begin
                tmr_start = 1'b1;
                next_state = FRRL_OFF_WAIT;
              end
            end
            default: begin
              next_oe = 1'b0;
              next_state = FRRL_LATCHED;
            end
          endcase
        end
      end
      // still running through the continue delay
      FRRL_CONT_WAIT: begin
        if (!fault) begin
          next_state = FRRL_RUN;
        end else if (tmr_done) begin
          next_oe = 1'b0;
          if (cfg.retries == FRRL_RETRY_NONE) begin
            next_state = FRRL_LATCHED;
          end else begin
            tmr_start = 1'b1;
            next_state = FRRL_OFF_WAIT;
          end
        end
      end
      // off, waiting out spacing before a restart
      FRRL_OFF_WAIT: begin
        next_oe = 1'b0;
        if (cmd_off || bias_lost || other_fault) begin
          next_state = FRRL_LATCHED;
        end else if (tmr_done) begin
          next_oe = 1'b1;
          next_pulse = 1'b1;
          next_tries = tries + 3'h1;
          tmr_start = 1'b1;
          next_state = FRRL_RESTART;
        end
      end
      // restart attempt under way
      FRRL_RESTART: begin
        if (restart_ok) begin
          next_state = FRRL_RUN;
        end else if (cmd_off || bias_lost || other_fault) begin
          next_oe = 1'b0;
          next_state = FRRL_LATCHED;
        end else if (tmr_done) begin
          next_oe = 1'b0;
          if (limit_hit) begin
            next_state = FRRL_LATCHED;
          end else begin
            next_oe = 1'b1;
            next_pulse = 1'b1;
            next_tries = (tries == 3'h7) ? tries : tries + 3'h1;
            tmr_start = 1'b1;
          end
        end
      end
      // off until clear_bit or clear_faults, with cmd_off and bias_lost low
      FRRL_LATCHED: begin
        next_oe = 1'b0;
        if (cleared && !cmd_off && !bias_lost) begin
          next_state = FRRL_RUN;
        end
      end
      default: begin
        next_state = FRRL_LATCHED;
        next_oe = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= FRRL_RUN;
      tries <= '0;
      output_enable <= 1'b1;
      restart_pulse <= 1'b0;
    end else begin
      state <= next_state;
      tries <= next_tries;
      output_enable <= next_oe;
      restart_pulse <= next_pulse;
    end
  end
  assign fault_latched = (state == FRRL_LATCHED);
  assign attempts = tries;
  // ****************************************************************
  // delay timer
  // ****************************************************************
  frrl_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(tmr_start),
    .stop(state == FRRL_RUN && !tmr_start),
    .count(delay_clocks(cfg.delay, unit)),
    .done(tmr_done)
  );
endmodule
`default_nettype wire

// *** pkg/frrl_pkg.sv ***
// fault retry response logic: shared constants, field layout, types
// assumes a register-write port from the pmbus command decoder upstream
package frrl_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] FRRL_CMD_RESPONSE = 8'hc4; // response byte command code
  localparam logic [7:0] FRRL_CMD_TIME_UNIT = 8'hd2; // delay time-unit register code
  localparam logic [7:0] FRRL_RESPONSE_RESET = 8'h00; // response byte after reset
  localparam logic [15:0] FRRL_UNIT_RESET = 16'h0001; // time unit (clocks) after reset
  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int FRRL_RESP_HI = 7; // response field msb
  localparam int FRRL_RESP_LO = 6; // response field lsb
  localparam int FRRL_RETRY_HI = 5; // retry field msb
  localparam int FRRL_RETRY_LO = 3; // retry field lsb
  localparam int FRRL_DELAY_HI = 2; // delay field msb
  localparam int FRRL_DELAY_LO = 0; // delay field lsb
  localparam logic [1:0] FRRL_RESP_IGNORE = 2'h0; // keep running
  localparam logic [1:0] FRRL_RESP_CONTINUE = 2'h1; // run for delay then retry
  localparam logic [1:0] FRRL_RESP_DISABLE_RETRY = 2'h2; // shut down then retry
  localparam logic [1:0] FRRL_RESP_LATCH = 2'h3; // off until cleared
  localparam logic [2:0] FRRL_RETRY_NONE = 3'h0; // no restart
  localparam logic [2:0] FRRL_RETRY_FOREVER = 3'h7; // restart without limit
  localparam int FRRL_CNT_W = 24; // delay counter width (128 x 16-bit unit)
  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] response; // action on fault
    logic [2:0] retries; // restart count code
    logic [2:0] delay; // power-of-two delay code
  } frrl_resp_t;
  typedef struct packed {
    logic wr; // one-cycle write strobe
    logic [7:0] cmd; // command code
    logic [15:0] data; // write data, byte commands use low bits
  } frrl_wr_t;
  typedef enum logic [2:0] {
    FRRL_RUN, FRRL_CONT_WAIT, FRRL_OFF_WAIT, FRRL_RESTART, FRRL_LATCHED
  } frrl_state_t;
endpackage

// *** rtl/frrl_timer.sv ***
// fault retry response logic: delay timer
// assumes start is a one-cycle pulse; count is fixed while running
`timescale 1ns/100ps
`default_nettype none
module frrl_timer (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [frrl_pkg::FRRL_CNT_W-1:0] count,
  // status
  output logic done
);
  import frrl_pkg::*;
  // ****************************************************************
  // counter
  // ****************************************************************
  logic [FRRL_CNT_W-1:0] remain; // clocks left
  logic busy; // timer running
  logic [FRRL_CNT_W-1:0] next_remain;
  logic next_busy;
  logic next_done;
  // next state of the down counter
  always_comb begin
    next_remain = remain;
    next_busy = busy;
    next_done = 1'b0;
    if (stop) begin
      next_busy = 1'b0;
    end else if (start) begin
      next_remain = count;
      next_busy = 1'b1;
    end else if (busy) begin
      if (remain <= FRRL_CNT_W'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_remain = remain - FRRL_CNT_W'(1);
      end
    end
  end
  // register the counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      remain <= next_remain;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule
`default_nettype wire

// *** testbench/frrl_props.sv ***
// frrl checker: timing relations seen at the frrl_core ports
// assumes it is bound from the bench top; one clock domain
`timescale 1ns/100ps
`default_nettype none
module frrl_props (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // stimulus
  input wire frrl_pkg::frrl_wr_t wr_port,
  input wire logic fault,
  input wire logic other_fault,
  input wire logic cmd_off,
  input wire logic bias_lost,
  // results
  input wire frrl_pkg::frrl_resp_t response_rd,
  input wire logic [15:0] time_unit_rd,
  input wire logic output_enable,
  input wire logic restart_pulse,
  input wire logic fault_latched
);
  import frrl_pkg::*;
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_resp_write: assert property (wr_port.wr && wr_port.cmd == FRRL_CMD_RESPONSE
    |=> response_rd == $past(wr_port.data[7:0])) else $error("response write lost");
  a_unit_write: assert property (wr_port.wr && wr_port.cmd == FRRL_CMD_TIME_UNIT
    |=> time_unit_rd == $past(wr_port.data)) else $error("time unit write lost");
  a_ignore_runs: assert property (response_rd.response == FRRL_RESP_IGNORE
    && output_enable && !(other_fault | cmd_off | bias_lost) |=> output_enable)
    else $error("ignore response dropped output");
  a_cont_runs: assert property ($rose(fault) && output_enable
    && response_rd.response == FRRL_RESP_CONTINUE |=> output_enable)
    else $error("continue response dropped output at once");
  a_disable_now: assert property ($rose(fault) && output_enable
    && response_rd.response[1] |=> !output_enable) else $error("output not disabled");
  a_latch_dark: assert property (fault_latched |-> !output_enable)
    else $error("output on while latched");
  a_latch_holds: assert property (fault_latched && (cmd_off || bias_lost)
    |=> fault_latched) else $error("latch released during off");
  a_no_restart: assert property (restart_pulse
    |-> response_rd.retries != FRRL_RETRY_NONE) else $error("restart with retry zero");
  a_pulse_single: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse too long");
endmodule
`default_nettype wire

// *** testbench/frrl_stage.sv ***
// frrl power stage model: reports regulation after a restart
// assumes output_enable from frrl_core; heal set by the bench
`timescale 1ns/100ps
`default_nettype none
module frrl_stage (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // core side
  input wire logic output_enable,
  input wire logic heal,
  // status back
  output logic restart_ok
);
  // regulation one cycle after enable, only when healthy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      restart_ok <= 1'b0;
    end else begin
      restart_ok <= output_enable & heal;
    end
  end
endmodule
`default_nettype wire

// *** testbench/frrl_bench.sv ***
// frrl bench: register writes and fault episodes on frrl_core
// assumes frrl_props and frrl_stage are compiled first
`timescale 1ns/100ps
`default_nettype none
module frrl_bench;
  import frrl_pkg::*;
  logic clk = 0, nrst = 0, fault = 0, heal = 0, other_fault = 0;
  logic clear_bit = 0, clear_faults = 0, cmd_off = 0, bias_lost = 0;
  frrl_wr_t wr_port = '0;
  frrl_resp_t response_rd;
  logic [15:0] time_unit_rd;
  logic output_enable, restart_pulse, fault_latched, restart_ok;
  logic [2:0] attempts;
  int err_count = 0, samples_checked = 0, cyc = 0, pulses = 0, last = 0, gap = 0, e;
  frrl_core uut (.clk, .nrst, .wr_port, .fault, .restart_ok, .other_fault, .clear_bit,
    .clear_faults, .cmd_off, .bias_lost, .response_rd, .time_unit_rd, .output_enable,
    .restart_pulse, .fault_latched, .attempts);
  frrl_stage stage (.clk, .nrst, .output_enable, .heal, .restart_ok);
  always #5 clk = ~clk;
  // cycle count, restart count, smallest restart spacing, hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (restart_pulse === 1'b1) begin
      pulses <= pulses + 1;
      last <= cyc;
      if (pulses > 0 && cyc - last < gap) gap <= cyc - last;
    end
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] cmd, logic [15:0] data);
    wr_port <= '{1'b1, cmd, data};
    step(1);
    wr_port.wr <= 1'b0;
    step(1);
  endtask
  // write the response, raise the fault, wait for latch or n cycles
  task automatic episode(logic [7:0] resp, int n);
    wr(FRRL_CMD_RESPONSE, {8'h00, resp});
    pulses <= 0;
    gap <= 9999;
    fault <= 1'b1;
    repeat (n) begin
      step(1);
      if (fault_latched === 1'b1) break;
    end
    step(1);
  endtask
  task automatic clear_all();
    fault <= 1'b0;
    clear_faults <= 1'b1;
    step(1);
    clear_faults <= 1'b0;
    step(3);
    chk("latched", 0, fault_latched);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    step(12);
    nrst <= 1'b1;
    step(1);
    chk("response", FRRL_RESPONSE_RESET, response_rd);
    chk("unit", FRRL_UNIT_RESET, time_unit_rd);
    wr(8'hc5, 16'h00ff);
    chk("response", FRRL_RESPONSE_RESET, response_rd);
    wr(FRRL_CMD_TIME_UNIT, 16'h0003);
    // every delay code, counts one to six, every restart failing
    for (int d = 0; d < 8; d++) begin
      e = 3 << d;
      episode({2'h2, 3'(d % 6 + 1), 3'(d)}, 5000);
      chk("restarts", 16'(d % 6 + 1), 16'(pulses));
      chk("attempts", 16'(d % 6 + 1), 16'(attempts));
      chk("enable", 0, output_enable);
      if (d % 6 > 0) chk("spacing", 1, 16'(gap >= e && gap <= e + 8));
      clear_all();
    end
    episode({2'h2, 3'h0, 3'h0}, 300);
    chk("restarts", 0, 16'(pulses));
    fault <= 1'b0;
    clear_bit <= 1'b1;
    step(1);
    clear_bit <= 1'b0;
    step(3);
    chk("latched", 0, fault_latched);
    episode({2'h3, 3'h1, 3'h0}, 300);
    chk("restarts", 0, 16'(pulses));
    bias_lost <= 1'b1;
    fault <= 1'b0;
    clear_faults <= 1'b1;
    step(3);
    chk("latched", 1, fault_latched);
    bias_lost <= 1'b0;
    clear_all();
    episode({2'h2, 3'h7, 3'h0}, 400);
    chk("endless", 1, 16'(pulses > 8 && fault_latched === 1'b0));
    cmd_off <= 1'b1;
    step(20);
    pulses <= 0;
    step(60);
    chk("restarts", 0, 16'(pulses));
    cmd_off <= 1'b0;
    clear_all();
    // endless retry ended by another fault
    episode({2'h2, 3'h7, 3'h0}, 40);
    other_fault <= 1'b1;
    step(10);
    chk("latched", 1, fault_latched);
    other_fault <= 1'b0;
    clear_all();
    // a restart that regulates never latches
    heal <= 1'b1;
    episode({2'h2, 3'h1, 3'h0}, 40);
    chk("healed", 0, fault_latched);
    fault <= 1'b0;
    step(20);
    heal <= 1'b0;
    chk("enable", 1, output_enable);
    episode({2'h0, 3'h1, 3'h0}, 100);
    chk("enable", 1, output_enable);
    clear_all();
    episode({2'h1, 3'h2, 3'h2}, 8);
    chk("enable", 1, output_enable);
    fault <= 1'b0;
    step(50);
    chk("restarts", 0, 16'(pulses));
    episode({2'h1, 3'h2, 3'h2}, 3000);
    chk("restarts", 2, 16'(pulses));
    clear_all();
    chk("enable", 1, output_enable);
    end_sim();
  end
endmodule
bind frrl_core frrl_props u_props (.clk, .nrst, .wr_port, .fault, .other_fault, .cmd_off,
  .bias_lost, .response_rd, .time_unit_rd, .output_enable, .restart_pulse, .fault_latched);
`default_nettype wire
